/* File: pte_pkg.sv */
// Package with register map, field layout and encodings of the pin task and event channel block
`default_nettype none

package pte_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_TASK_OUT  = 12'h000;
  localparam logic [11:0] OFF_TASK_SET  = 12'h030;
  localparam logic [11:0] OFF_TASK_CLR  = 12'h060;
  localparam logic [11:0] OFF_SUB_OUT   = 12'h080;
  localparam logic [11:0] OFF_SUB_SET   = 12'h0B0;
  localparam logic [11:0] OFF_SUB_CLR   = 12'h0E0;
  localparam logic [11:0] OFF_EV_IN     = 12'h100;
  localparam logic [11:0] OFF_EV_PORT   = 12'h17C;
  localparam logic [11:0] OFF_PUB_IN    = 12'h180;
  localparam logic [11:0] OFF_PUB_PORT  = 12'h1FC;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_SET  = 12'h304;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_CLEAR  = 12'h308;
  localparam logic [11:0] OFF_CONFIG    = 12'h510;
  localparam logic [11:0] REG_STRIDE    = 12'h004;

  // ==========================================================================
  // Channel configuration fields
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_PSEL_LSB    = 8;
  localparam int CFG_PSEL_W      = 5;
  localparam int CFG_PORT_BIT    = 13;
  localparam int CFG_POL_LSB     = 16;
  localparam int CFG_INITIAL_OUTPUT_LEVEL_BIT = 20;
  localparam int PIN_IDX_W       = CFG_PSEL_W + 1;

  // ==========================================================================
  // Subscribe and publish fields, interrupt enable port bit
  localparam int SUB_IDX_W       = 8;
  localparam int SUB_EN_BIT      = 31;
  localparam int INT_PORT_BIT    = 31;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] SUB_RESET   = 32'h0000_0000;
  localparam logic [31:0] INTEN_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    PTE_MODE_OFF   = 2'h0,
    PTE_MODE_EVENT = 2'h1,
    PTE_MODE_RSVD  = 2'h2,
    PTE_MODE_TASK  = 2'h3
  } pte_mode_t;

  typedef enum logic [1:0] {
    PTE_POL_NONE    = 2'h0,
    PTE_POL_RISING  = 2'h1,
    PTE_POL_FALLING = 2'h2,
    PTE_POL_TOGGLE  = 2'h3
  } pte_pol_t;

endpackage

`default_nettype wire

/* File: pte_channels.sv */
// Eight pin channels: edge events on inputs, set/clear/polarity tasks on outputs
// Behaviour
// - Each channel keeps an event flag: 1 after qualifying pin activity, else 0.
// - One port event flag rises on activity from the GPIO sense mechanism.
// - Interrupt-enable-set channel bit: write 1 enables, 0 ignored, reads enable state.
// - Interrupt-enable-set port bit: write 1 enables port interrupt, reads enable state.
// - Interrupt-enable-clear channel bit: write 1 disables; reads the shared enable state.
// - Interrupt-enable-clear port bit: write 1 disables, write 0 leaves it unchanged.
// - Mode 0 leaves the pin alone, makes no events and ignores all tasks.
// - Mode 1 makes the pin an input and raises events on the polarity condition.
// - Mode 3 makes the pin an output and applies task operations when triggered.
// - In task mode the channel owns the pin; general GPIO output writes are ignored.
// - Pin-select and port-number fields choose the one physical pin of a channel.
// - Polarity task: 0 nothing, 1 drive high, 2 drive low, 3 invert.
// - Entering task mode drives the pin first to the initial output level.
// - Set task drives the pin high, clear task drives it low, regardless of polarity.
// - Each task has a subscription register: interconnect channel index plus enable bit.
`timescale 1ns/1ps
`default_nettype none

module pte_channels
  import pte_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int IC_N = 256
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Event interconnect
  input  wire logic [IC_N-1:0]        ic_trig,
  output logic      [IC_N-1:0]        ic_pub,
  // General GPIO module side
  input  wire logic [2**PIN_IDX_W-1:0] gpio_sw_out,
  input  wire logic [2**PIN_IDX_W-1:0] gpio_sw_oe,
  input  wire logic                   port_sense,
  // Pins
  input  wire logic [2**PIN_IDX_W-1:0] pin_in,
  output logic      [2**PIN_IDX_W-1:0] pin_out,
  output logic      [2**PIN_IDX_W-1:0] pin_oe,
  // Interrupt
  output logic                        irq
);

  localparam int NPIN = 2**PIN_IDX_W;

  // ==========================================================================
  // Storage
  logic [1:0]           mode_q    [NCH];
  logic [CFG_PSEL_W-1:0] psel_q   [NCH];
  logic                 port_q    [NCH];
  logic [1:0]           pol_q     [NCH];
  logic                 initial_output_level_q [NCH];
  logic [31:0]          sub_out_q [NCH];
  logic [31:0]          sub_set_q [NCH];
  logic [31:0]          sub_clr_q [NCH];
  logic [31:0]          pub_in_q  [NCH];
  logic [31:0]          pub_port_q;
  logic [NCH-1:0]       ev_in_q;
  logic                 ev_port_q;
  logic [NCH-1:0]       inten_in_q;
  logic                 inten_port_q;
  logic [NCH-1:0]       lvl_q;
  logic [NPIN-1:0]      sync1_q;
  logic [NPIN-1:0]      sync2_q;
  logic [NPIN-1:0]      prev_q;
  logic                 sense_prev_q;
  logic [31:0]          rdata_q;
  logic [NPIN-1:0]      pin_out_q;
  logic [NPIN-1:0]      pin_oe_q;
  logic [IC_N-1:0]      ic_pub_q;

  // Per channel decode and event wires
  logic [NCH-1:0]       new_ev;
  logic [NCH-1:0]       lvl_d;
  logic [NCH-1:0]       wr_ev;
  logic [NCH-1:0]       is_task;
  logic [NCH-1:0]       is_event;
  logic [PIN_IDX_W-1:0] sel_pin  [NCH];
  logic [31:0]          rd_ch    [NCH];
  logic [NCH-1:0]       hit_ch;

  // ==========================================================================
  // Global register decode
  wire wr_interrupt_enable_set  = reg_wr && (reg_addr == OFF_INTERRUPT_ENABLE_SET);
  wire wr_interrupt_enable_clear  = reg_wr && (reg_addr == OFF_INTERRUPT_ENABLE_CLEAR);
  wire wr_ev_port   = reg_wr && (reg_addr == OFF_EV_PORT);
  wire wr_pub_port  = reg_wr && (reg_addr == OFF_PUB_PORT);
  wire hit_glob     = (reg_addr == OFF_INTERRUPT_ENABLE_SET) || (reg_addr == OFF_INTERRUPT_ENABLE_CLEAR) ||
                      (reg_addr == OFF_EV_PORT) || (reg_addr == OFF_PUB_PORT);
  wire [31:0] inten_rd = {inten_port_q, {(31-NCH){1'b0}}, inten_in_q};
  wire [31:0] rd_glob  = (reg_addr == OFF_EV_PORT)  ? {31'h0000_0000, ev_port_q} :
                         (reg_addr == OFF_PUB_PORT) ? pub_port_q :
                         inten_rd;

  wire new_port_ev = port_sense && !sense_prev_q;

  // ==========================================================================
  // Channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire [11:0] a_off  = 12'(i) * REG_STRIDE;
    wire a_tout = (reg_addr == OFF_TASK_OUT + a_off);
    wire a_tset = (reg_addr == OFF_TASK_SET + a_off);
    wire a_tclr = (reg_addr == OFF_TASK_CLR + a_off);
    wire a_sout = (reg_addr == OFF_SUB_OUT + a_off);
    wire a_sset = (reg_addr == OFF_SUB_SET + a_off);
    wire a_sclr = (reg_addr == OFF_SUB_CLR + a_off);
    wire a_ev   = (reg_addr == OFF_EV_IN + a_off);
    wire a_pub  = (reg_addr == OFF_PUB_IN + a_off);
    wire a_cfg  = (reg_addr == OFF_CONFIG + a_off);
    wire wr_cfg = reg_wr && a_cfg;
    wire [1:0] new_mode = reg_wdata[CFG_MODE_LSB +: 2];

    wire sub_o = sub_out_q[i][SUB_EN_BIT] && ic_trig[sub_out_q[i][SUB_IDX_W-1:0]];
    wire sub_s = sub_set_q[i][SUB_EN_BIT] && ic_trig[sub_set_q[i][SUB_IDX_W-1:0]];
    wire sub_c = sub_clr_q[i][SUB_EN_BIT] && ic_trig[sub_clr_q[i][SUB_IDX_W-1:0]];
    wire trig_out = (reg_wr && a_tout && reg_wdata[0]) || sub_o;
    wire trig_set = (reg_wr && a_tset && reg_wdata[0]) || sub_s;
    wire trig_clr = (reg_wr && a_tclr && reg_wdata[0]) || sub_c;

    assign is_task[i]  = (mode_q[i] == PTE_MODE_TASK);
    assign is_event[i] = (mode_q[i] == PTE_MODE_EVENT);
    assign wr_ev[i]    = reg_wr && a_ev;

    // physical pin from port and pin select
    assign sel_pin[i] = {port_q[i], psel_q[i]};

    // edges seen on synchronised samples only
    wire smp  = sync2_q[sel_pin[i]];
    wire prv  = prev_q[sel_pin[i]];
    wire rise = smp && !prv;
    wire fall = !smp && prv;

    wire pol_hit = (pol_q[i] == PTE_POL_RISING)  ? rise :
                   (pol_q[i] == PTE_POL_FALLING) ? fall :
                   (pol_q[i] == PTE_POL_TOGGLE)  ? (rise || fall) : 1'b0;
    assign new_ev[i] = is_event[i] && pol_hit;

    wire out_lvl = (pol_q[i] == PTE_POL_RISING)  ? 1'b1 :
                   (pol_q[i] == PTE_POL_FALLING) ? 1'b0 :
                   (pol_q[i] == PTE_POL_TOGGLE)  ? !lvl_q[i] : lvl_q[i];

    // initial level on entering task mode
    // clear beats set, both beat the polarity task
    // task operations in task mode only
    assign lvl_d[i] = (wr_cfg && new_mode == PTE_MODE_TASK) ? reg_wdata[CFG_INITIAL_OUTPUT_LEVEL_BIT] :
                      !is_task[i] ? lvl_q[i] :
                      trig_clr    ? 1'b0 :
                      trig_set    ? 1'b1 :
                      trig_out    ? out_lvl : lvl_q[i];

    wire [31:0] cfg_rd = {11'h000, initial_output_level_q[i], 2'h0, pol_q[i], 2'h0, port_q[i],
                          psel_q[i], 6'h00, mode_q[i]};
    assign hit_ch[i] = a_tout || a_tset || a_tclr || a_sout || a_sset || a_sclr ||
                       a_ev || a_pub || a_cfg;
    assign rd_ch[i]  = a_sout ? sub_out_q[i] :
                       a_sset ? sub_set_q[i] :
                       a_sclr ? sub_clr_q[i] :
                       a_ev   ? {31'h0000_0000, ev_in_q[i]} :
                       a_pub  ? pub_in_q[i] :
                       a_cfg  ? cfg_rd : RD_ZERO;

    wire [31:0] sub_mask = {1'b1, {(31-SUB_IDX_W){1'b0}}, {SUB_IDX_W{1'b1}}};

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mode_q[i]    <= CFG_RESET[CFG_MODE_LSB +: 2];
        psel_q[i]    <= CFG_RESET[CFG_PSEL_LSB +: CFG_PSEL_W];
        port_q[i]    <= CFG_RESET[CFG_PORT_BIT];
        pol_q[i]     <= CFG_RESET[CFG_POL_LSB +: 2];
        initial_output_level_q[i] <= CFG_RESET[CFG_INITIAL_OUTPUT_LEVEL_BIT];
        sub_out_q[i] <= SUB_RESET;
        sub_set_q[i] <= SUB_RESET;
        sub_clr_q[i] <= SUB_RESET;
        pub_in_q[i]  <= SUB_RESET;
        lvl_q[i]     <= 1'b0;
      end else begin
        if (wr_cfg) begin
          mode_q[i]    <= new_mode;
          psel_q[i]    <= reg_wdata[CFG_PSEL_LSB +: CFG_PSEL_W];
          port_q[i]    <= reg_wdata[CFG_PORT_BIT];
          pol_q[i]     <= reg_wdata[CFG_POL_LSB +: 2];
          initial_output_level_q[i] <= reg_wdata[CFG_INITIAL_OUTPUT_LEVEL_BIT];
        end
        if (reg_wr && a_sout) sub_out_q[i] <= reg_wdata & sub_mask;
        if (reg_wr && a_sset) sub_set_q[i] <= reg_wdata & sub_mask;
        if (reg_wr && a_sclr) sub_clr_q[i] <= reg_wdata & sub_mask;
        if (reg_wr && a_pub)  pub_in_q[i]  <= reg_wdata & sub_mask;
        lvl_q[i] <= lvl_d[i];
      end
    end
  end

  // ==========================================================================
  // Event flags and interrupt enables
  // hardware set wins over a software write
  wire [NCH-1:0] ev_wval = {NCH{reg_wdata[0]}};
  wire [NCH-1:0] ev_in_d = ((wr_ev & ev_wval) | (~wr_ev & ev_in_q)) | new_ev;
  wire ev_port_d = (wr_ev_port ? reg_wdata[0] : ev_port_q) || new_port_ev;

  // set register enables channel bits written 1
  // clear register disables channel bits written 1
  wire [NCH-1:0] inten_in_d = (inten_in_q | ({NCH{wr_interrupt_enable_set}} & reg_wdata[NCH-1:0])) &
                              ~({NCH{wr_interrupt_enable_clear}} & reg_wdata[NCH-1:0]);
  // port enable clear, 0 leaves it alone
  wire inten_port_d = (inten_port_q || (wr_interrupt_enable_set && reg_wdata[INT_PORT_BIT])) &&
                      !(wr_interrupt_enable_clear && reg_wdata[INT_PORT_BIT]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_in_q      <= '0;
      ev_port_q    <= 1'b0;
      inten_in_q   <= INTEN_RESET[NCH-1:0];
      inten_port_q <= INTEN_RESET[INT_PORT_BIT];
      pub_port_q   <= SUB_RESET;
      sense_prev_q <= 1'b0;
    end else begin
      ev_in_q      <= ev_in_d;
      ev_port_q    <= ev_port_d;
      inten_in_q   <= inten_in_d;
      inten_port_q <= inten_port_d;
      sense_prev_q <= port_sense;
      if (wr_pub_port) begin
        pub_port_q <= reg_wdata & {1'b1, {(31-SUB_IDX_W){1'b0}}, {SUB_IDX_W{1'b1}}};
      end
    end
  end

  assign irq = |(ev_in_q & inten_in_q) || (ev_port_q && inten_port_q);

  // ==========================================================================
  // Publish new events onto the interconnect
  logic [IC_N-1:0] pub_d;
  always_comb begin
    pub_d = '0;
    for (int i = 0; i < NCH; i++) begin
      if (new_ev[i] && pub_in_q[i][SUB_EN_BIT]) begin
        pub_d[pub_in_q[i][SUB_IDX_W-1:0]] = 1'b1;
      end
    end
    if (new_port_ev && pub_port_q[SUB_EN_BIT]) begin
      pub_d[pub_port_q[SUB_IDX_W-1:0]] = 1'b1;
    end
  end

  // ==========================================================================
  // Pin ownership; lowest channel wins on a shared pin
  logic [NPIN-1:0] pout_d;
  logic [NPIN-1:0] poe_d;
  always_comb begin
    pout_d = gpio_sw_out;
    poe_d  = gpio_sw_oe;
    for (int i = NCH - 1; i >= 0; i--) begin
      // task mode overrides general GPIO output
      if (is_task[i]) begin
        pout_d[sel_pin[i]] = lvl_q[i];
        poe_d[sel_pin[i]]  = 1'b1;
      // event mode holds the pin as input
      end else if (is_event[i]) begin
        poe_d[sel_pin[i]]  = 1'b0;
      end
      // disabled channel leaves the pin to GPIO
    end
  end

  // ==========================================================================
  // Read data, pins and synchronisers
  logic [31:0] rd_any;
  logic        hit_any;
  always_comb begin
    rd_any  = hit_glob ? rd_glob : RD_ZERO;
    hit_any = hit_glob;
    for (int i = 0; i < NCH; i++) begin
      rd_any  = rd_any | rd_ch[i];
      hit_any = hit_any | hit_ch[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q   <= RD_ZERO;
      sync1_q   <= '0;
      sync2_q   <= '0;
      prev_q    <= '0;
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      ic_pub_q  <= '0;
    end else begin
      rdata_q   <= (reg_rd && hit_any) ? rd_any : RD_ZERO;
      sync1_q   <= pin_in;
      sync2_q   <= sync1_q;
      prev_q    <= sync2_q;
      pin_out_q <= pout_d;
      pin_oe_q  <= poe_d;
      ic_pub_q  <= pub_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out   = pin_out_q;
  assign pin_oe    = pin_oe_q;
  assign ic_pub    = ic_pub_q;

endmodule

`default_nettype wire

/* File: pte_channels_checker.sv */
// Port-level assertions for the pin task and event channel block
`timescale 1ns/1ps
`default_nettype none

module pte_channels_checker
  import pte_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int IC_N = 256
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Register port
  input wire logic [11:0]             reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  // Interconnect
  input wire logic [IC_N-1:0]         ic_trig,
  input wire logic [IC_N-1:0]         ic_pub,
  // GPIO side and pins
  input wire logic [2**PIN_IDX_W-1:0] gpio_sw_out,
  input wire logic [2**PIN_IDX_W-1:0] gpio_sw_oe,
  input wire logic                    port_sense,
  input wire logic [2**PIN_IDX_W-1:0] pin_in,
  input wire logic [2**PIN_IDX_W-1:0] pin_out,
  input wire logic [2**PIN_IDX_W-1:0] pin_oe,
  input wire logic                    irq
);
  // ==========================================================================
  // Channel 0 setup tracked from the bus
  localparam logic [31:0] EN_MASK = 32'h8000_00FF;
  logic [31:0] cfg0_q;
  wire logic   cfg0_wr   = reg_wr && reg_addr == OFF_CONFIG;
  wire logic   cfg0_task = cfg0_wr && reg_wdata[1:0] == 2'h3;
  wire logic   task0_ok  = reg_wr && reg_wdata[0] && cfg0_q[1:0] == 2'h3 && ic_trig == '0;
  wire logic   en_wr     = reg_wr && reg_addr == OFF_INTERRUPT_ENABLE_SET;
  wire logic   dis_wr    = reg_wr && reg_addr == OFF_INTERRUPT_ENABLE_CLEAR;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg0_q <= 32'h0000_0000;
    end else if (cfg0_wr) begin
      cfg0_q <= reg_wdata;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_event_flag_bit: assert property (reg_rd && reg_addr == OFF_EV_IN |=> reg_rdata[31:1] == 31'h0)
    else $error("event flag read shows more than one bit");
  a_task_read_zero: assert property (reg_rd && reg_addr < OFF_SUB_OUT |=> reg_rdata == 32'h0000_0000)
    else $error("task register read not zero");
  a_enset_read_back: assert property (en_wr ##1 (reg_rd && reg_addr == OFF_INTERRUPT_ENABLE_SET) |=>
    (reg_rdata & $past(reg_wdata, 2) & EN_MASK) == ($past(reg_wdata, 2) & EN_MASK))
    else $error("enable set bits not read back");
  a_enclr_read_back: assert property (dis_wr ##1 (reg_rd && reg_addr == OFF_INTERRUPT_ENABLE_CLEAR) |=>
    (reg_rdata & $past(reg_wdata, 2) & EN_MASK) == 32'h0000_0000)
    else $error("enable clear bits still read as set");
  a_irq_all_off: assert property (dis_wr && reg_wdata == EN_MASK |=> !irq)
    else $error("interrupt high with all enables cleared");
  a_init_level_out: assert property (cfg0_task |-> ##2 pin_out[$past(reg_wdata[13:8], 2)] == $past(reg_wdata[20], 2))
    else $error("pin not at initial level after task config");
  a_set_drives_high: assert property ((task0_ok && reg_addr == OFF_TASK_SET) ##1 !cfg0_wr |=> pin_out[cfg0_q[13:8]])
    else $error("set task did not drive pin high");
  a_clr_drives_low: assert property ((task0_ok && reg_addr == OFF_TASK_CLR) ##1 !cfg0_wr |=> !pin_out[cfg0_q[13:8]])
    else $error("clear task did not drive pin low");

  c_task_config: cover property (cfg0_task);
  c_irq_high: cover property (irq);
  c_publish: cover property (ic_pub != '0);
endmodule

bind pte_channels pte_channels_checker #(.NCH(NCH), .IC_N(IC_N)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ic_trig(ic_trig), .ic_pub(ic_pub),
  .gpio_sw_out(gpio_sw_out), .gpio_sw_oe(gpio_sw_oe), .port_sense(port_sense),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
);

`default_nettype wire

/* File: pte_pin_model.sv */
// Pad model: loops driven pads back, applies bench levels, lets floating pads wander
`timescale 1ns/1ps
`default_nettype none

module pte_pin_model (
  // Clock
  input  wire logic        clk,
  // Pads from the block
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe,
  // Levels applied from outside
  input  wire logic [63:0] ext_level,
  input  wire logic [63:0] ext_drive,
  // Pads into the block
  output logic      [63:0] pin_in
);
  // ==========================================================================
  // Undriven pads change every cycle so no stale level is trusted
  logic [63:0] float_q = 64'h0;
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) | (~pin_oe & ~ext_drive & float_q);
endmodule

`default_nettype wire

/* File: test_pte_channels.sv */
// Self-checking testbench of the pin task and event channel block
`timescale 1ns/1ps
`default_nettype none

module test_pte_channels;
  import pte_pkg::*;
  // ==========================================================================
  // Signals
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [11:0]  reg_addr = 12'h000;
  logic [31:0]  reg_wdata = 32'h0000_0000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic [255:0] ic_trig = 256'h0;
  logic [255:0] ic_pub;
  logic [63:0]  gpio_sw_out = 64'h0;
  logic [63:0]  gpio_sw_oe = 64'hFFFF_FFFF_FFFF_FFFF;
  logic         port_sense = 1'b0;
  logic [63:0]  ext_level = 64'h0;
  logic [63:0]  ext_drive = 64'h0000_0000_0000_0008;
  logic [63:0]  pin_in;
  logic [63:0]  pin_out;
  logic [63:0]  pin_oe;
  logic         irq;
  logic         pub_seen = 1'b0;
  int           err_total = 0;
  int           tests_run = 0;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (ic_pub[9] === 1'b1) pub_seen <= 1'b1;
  end

  pte_channels dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ic_trig(ic_trig), .ic_pub(ic_pub), .gpio_sw_out(gpio_sw_out),
    .gpio_sw_oe(gpio_sw_oe), .port_sense(port_sense), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq(irq));
  pte_pin_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .ext_drive(ext_drive), .pin_in(pin_in));

  // ==========================================================================
  // Bus and check tasks
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_rd(input string n, input logic [11:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(n, reg_rdata, exp);
  endtask
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check("enable", reg_rdata, exp);
  endtask
  task automatic trig(input int i);
    ic_trig[i] <= 1'b1;
    @(posedge clk);
    ic_trig[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_pin(input string n, input logic o);
    @(posedge clk);
    check(n, {30'h0, pin_oe[37], pin_out[37]}, {30'h0, 1'b1, o});
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [5:0] p, input logic [1:0] pol,
                                      input logic init);
    return {11'h000, init, 2'h0, pol, 2'h0, p, 6'h00, m};
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_rd("cfg0", OFF_CONFIG, CFG_RESET);
    chk_rd("ev0", OFF_EV_IN, 32'h0000_0000);
    chk_rd("inten", OFF_INTERRUPT_ENABLE_SET, INTEN_RESET);
    chk_rd("unmapped", 12'hFFC, RD_ZERO);
    chk_rd("task_reg", OFF_TASK_SET, RD_ZERO);
    wr_rd(OFF_INTERRUPT_ENABLE_SET, 32'h0000_0005, 32'h0000_0005);
    wr_rd(OFF_INTERRUPT_ENABLE_SET, 32'h0000_0000, 32'h0000_0005);
    wr_rd(OFF_INTERRUPT_ENABLE_SET, 32'h8000_0000, 32'h8000_0005);
    wr_rd(OFF_INTERRUPT_ENABLE_CLEAR, 32'h0000_0001, 32'h8000_0004);
    wr_rd(OFF_INTERRUPT_ENABLE_CLEAR, 32'h0000_0000, 32'h8000_0004);
    wr_rd(OFF_INTERRUPT_ENABLE_CLEAR, 32'h8000_0000, 32'h0000_0004);
    chk_rd("enset_view", OFF_INTERRUPT_ENABLE_SET, 32'h0000_0004);
    wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'h8000_00FF);
    wr(OFF_CONFIG, cfg(2'h0, 6'h25, 2'h1, 1'b1));
    wr(OFF_TASK_SET, 32'h0000_0001);
    chk_pin("off_set", 1'b0);
    wr(OFF_CONFIG, cfg(2'h3, 6'h25, 2'h0, 1'b1));
    chk_rd("cfg_back", OFF_CONFIG, cfg(2'h3, 6'h25, 2'h0, 1'b1));
    gpio_sw_oe <= 64'h0;
    gpio_sw_out <= 64'hFFFF_FFFF_FFFF_FFFF;
    chk_pin("init", 1'b1);
    wr(OFF_TASK_CLR, 32'h0000_0001);
    chk_pin("clr", 1'b0);
    wr(OFF_TASK_SET, 32'h0000_0001);
    chk_pin("set", 1'b1);
    for (int p = 0; p < 4; p++) begin
      wr(OFF_CONFIG, cfg(2'h3, 6'h25, p[1:0], ~p[0]));
      wr(OFF_TASK_OUT, 32'h0000_0001);
      chk_pin("out_task", p != 2);
    end
    wr(OFF_TASK_CLR, 32'h0000_0001);
    wr(OFF_SUB_SET, 32'h8000_0005);
    chk_rd("sub", OFF_SUB_SET, 32'h8000_0005);
    trig(5);
    chk_pin("sub_on", 1'b1);
    wr(OFF_TASK_CLR, 32'h0000_0001);
    wr(OFF_SUB_SET, 32'h0000_0005);
    trig(5);
    chk_pin("sub_off", 1'b0);
    gpio_sw_oe <= 64'hFFFF_FFFF_FFFF_FFFF;
    gpio_sw_out <= 64'h0;
    wr(OFF_PUB_IN + REG_STRIDE, 32'h8000_0009);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'h0000_0002);
    for (int p = 0; p < 4; p++) begin
      wr(OFF_CONFIG + REG_STRIDE, cfg(2'h1, 6'h03, p[1:0], 1'b1));
      repeat (4) @(posedge clk);
      wr(OFF_EV_IN + REG_STRIDE, 32'h0000_0000);
      ext_level[3] <= 1'b1;
      repeat (6) @(posedge clk);
      check("ev_oe", {31'h0, pin_oe[3]}, 32'h0000_0000);
      chk_rd("ev_rise", OFF_EV_IN + REG_STRIDE, {31'h0, p[0]});
      wr(OFF_EV_IN + REG_STRIDE, 32'h0000_0000);
      ext_level[3] <= 1'b0;
      repeat (6) @(posedge clk);
      chk_rd("ev_fall", OFF_EV_IN + REG_STRIDE, {31'h0, p[1]});
      check("irq_ch", {31'h0, irq}, {31'h0, p[1]});
      wr(OFF_EV_IN + REG_STRIDE, 32'h0000_0000);
      chk_rd("ev_clr", OFF_EV_IN + REG_STRIDE, 32'h0000_0000);
    end
    check("publish", {31'h0, pub_seen}, 32'h0000_0001);
    port_sense <= 1'b1;
    repeat (3) @(posedge clk);
    port_sense <= 1'b0;
    chk_rd("port_ev", OFF_EV_PORT, 32'h0000_0001);
    wr(OFF_INTERRUPT_ENABLE_SET, 32'h8000_0000);
    check("irq_port", {31'h0, irq}, 32'h0000_0001);
    wr(OFF_INTERRUPT_ENABLE_CLEAR, 32'h8000_00FF);
    check("irq_off", {31'h0, irq}, 32'h0000_0000);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule

`default_nettype wire
